// [hdl/ffar_regs.sv]
// Fault cause and fault address capture registers behind a classic Wishbone slave.
//
// The placing of the registers and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// RULE_01: Writing a one to a cause bit clears it, writing zero leaves it alone.
// RULE_02: A failed vector table read sets cause bit 1, which is otherwise zero.
// RULE_03: A debug-caused escalation sets cause bit 31.
// RULE_04: An escalated configurable-priority fault sets cause bit 30; other bits read zero.
// RULE_05: The protection address is meaningful only while its valid flag is set.
// RULE_06: A protection fault captures the full 32-bit faulting data address.
// RULE_07: For split unaligned accesses the protection address is the part that faulted.
// RULE_08: With shared storage the protection address reads unknown while bus valid is set.
// RULE_09: The bus address is meaningful only while its valid flag is set.
// RULE_10: A precise bus fault captures the full 32-bit faulting data address.
// RULE_11: For unaligned bus faults the captured address is the one the instruction requested.
// RULE_12: With shared storage the bus address reads unknown while protection valid is set.
// RULE_13: The auxiliary fault register is not implemented: it reads zero and ignores writes.
// RULE_14: The precise error flag is raised only together with a bus address capture.
module ffar_regs #(
  parameter int unsigned AW = ffar_pkg::ADDR_W
) (
  input  wire logic          MCLK,
  input  wire logic          SRST,
  // Wishbone slave.
  input  wire logic          WB_CYC_I,
  input  wire logic          WB_STB_I,
  input  wire logic          WB_WE_I,
  input  wire logic [7:0]    WB_ADR_I,
  input  wire logic [3:0]    WB_SEL_I,
  input  wire logic [31:0]   WB_DAT_I,
  output logic      [31:0]   WB_DAT_O,
  output logic               WB_ACK_O,
  output logic               WB_ERR_O,
  // Fault events from the core, one-cycle pulses on MCLK.
  input  wire logic          DEBUG_FAULT,
  input  wire logic          FORCED_FAULT,
  input  wire logic          VECTOR_READ_FAULT,
  input  wire logic          PROT_FAULT,
  input  wire logic [AW-1:0] PROT_FAULT_ADDR,
  input  wire logic          BUS_FAULT,
  input  wire logic [AW-1:0] BUS_FAULT_ADDR,
  // State seen by the core.
  output logic               PROT_ADDR_VALID,
  output logic               BUS_ADDR_VALID,
  output logic               PRECISE_ERROR
);

  initial begin
    if (AW != ffar_pkg::ADDR_W) begin
      $error("ffar_regs: AW must be 32");
    end
    if (ffar_pkg::BIT_DEBUG >= ffar_pkg::DATA_W ||
        ffar_pkg::BIT_FORCED >= ffar_pkg::DATA_W) begin
      $error("ffar_regs: cause flag positions lie outside the data word");
    end
    if (ffar_pkg::BIT_PRECISE >= ffar_pkg::DATA_W / 4) begin
      $error("ffar_regs: status flags must sit in byte lane 0");
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////////
  // Bus decode.

  logic        req;
  logic        wr_req;
  logic        hit;
  logic [31:0] wmask;
  logic        ack_reg;
  logic        ack_next;
  logic        err_reg;
  logic        err_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  // Byte lanes widen to a bit mask shared by masked writes and masked clears.
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction : lane_mask

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [31:0] m);
    merge = (old_v & ~m) | (new_v & m);
  endfunction : merge

  always_comb begin
    hit = (WB_ADR_I == ffar_pkg::OFS_CAUSE) || (WB_ADR_I == ffar_pkg::OFS_PROT_ADDR) ||
          (WB_ADR_I == ffar_pkg::OFS_BUS_ADDR) || (WB_ADR_I == ffar_pkg::OFS_AUX) ||
          (WB_ADR_I == ffar_pkg::OFS_STATUS) || (WB_ADR_I == ffar_pkg::OFS_CONFIG);
  end

  // One request is answered once; the ack or err cycle itself blocks a double take.
  assign req    = WB_CYC_I && WB_STB_I && !ack_reg && !err_reg;
  assign wr_req = req && WB_WE_I && hit;
  assign wmask  = lane_mask(WB_SEL_I);

  //////////////////////////////////////////////////////////////////////////////////////////////////
  // Cause, status and config state.

  // Cause flags.
  logic        debug_reg;
  logic        debug_next;
  logic        forced_reg;
  logic        forced_next;
  logic        vector_reg;
  logic        vector_next;
  // Status flags and the shared-storage mode.
  logic        pvalid_reg;
  logic        pvalid_next;
  logic        bvalid_reg;
  logic        bvalid_next;
  logic        precise_reg;
  logic        precise_next;
  logic        shared_reg;
  logic        shared_next;
  // Clear strobes, capture strobes and the two stored words.
  logic [31:0] clr;
  logic        pw_en;
  logic [31:0] pw_data;
  logic        bw_en;
  logic [31:0] bw_data;
  logic [31:0] prot_word;
  logic [31:0] bus_word;

  // Lanes that are not selected clear nothing, so a byte write can clear one flag without
  // touching the others.
  always_comb begin
    clr = '0;
    if (wr_req && WB_ADR_I == ffar_pkg::OFS_CAUSE) begin
      clr = WB_DAT_I & wmask;
    end
  end

  always_comb begin
    // Hardware set wins over a software clear in the same cycle.
    debug_next  = DEBUG_FAULT || (debug_reg && !clr[ffar_pkg::BIT_DEBUG]); // see RULE_03 RULE_01
    forced_next = FORCED_FAULT ||
                  (forced_reg && !clr[ffar_pkg::BIT_FORCED]); // see RULE_04 RULE_01
    vector_next = VECTOR_READ_FAULT ||
                  (vector_reg && !clr[ffar_pkg::BIT_VECTOR]); // see RULE_02 RULE_01
    pvalid_next  = pvalid_reg;
    bvalid_next  = bvalid_reg;
    precise_next = precise_reg;
    shared_next  = shared_reg;
    // A flag stays set until software clears it; a repeated fault of the same kind only
    // refreshes the captured address.
    if (wr_req && WB_ADR_I == ffar_pkg::OFS_STATUS) begin
      // Status flags are write-one-to-clear as well.
      pvalid_next  = pvalid_reg && !(WB_DAT_I[ffar_pkg::BIT_PROT_VALID] && WB_SEL_I[0]);
      bvalid_next  = bvalid_reg && !(WB_DAT_I[ffar_pkg::BIT_BUS_VALID] && WB_SEL_I[0]);
      precise_next = precise_reg && !(WB_DAT_I[ffar_pkg::BIT_PRECISE] && WB_SEL_I[0]);
    end
    if (wr_req && WB_ADR_I == ffar_pkg::OFS_CONFIG && WB_SEL_I[0]) begin
      shared_next = WB_DAT_I[ffar_pkg::BIT_SHARED];
    end
    if (PROT_FAULT) begin
      pvalid_next = 1'b1;
    end
    if (BUS_FAULT) begin
      bvalid_next  = 1'b1;
      precise_next = 1'b1; // see RULE_14
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      debug_reg   <= 1'b0;
      forced_reg  <= 1'b0;
      vector_reg  <= 1'b0;
      pvalid_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      precise_reg <= 1'b0;
      shared_reg  <= 1'b0;
    end else begin
      debug_reg   <= debug_next;
      forced_reg  <= forced_next;
      vector_reg  <= vector_next;
      pvalid_reg  <= pvalid_next;
      bvalid_reg  <= bvalid_next;
      precise_reg <= precise_next;
      shared_reg  <= shared_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////////
  // Address capture. The core presents the faulting part address for protection faults and
  // the requested address for bus faults; a hardware capture wins over a software write.
  // A colliding software write is dropped because the capture is the newer fact about the
  // fault.

  always_comb begin
    pw_en   = PROT_FAULT;
    pw_data = PROT_FAULT_ADDR; // see RULE_06 RULE_07
    if (!PROT_FAULT && wr_req && WB_ADR_I == ffar_pkg::OFS_PROT_ADDR) begin
      pw_en   = 1'b1;
      pw_data = merge(prot_word, WB_DAT_I, wmask);
    end
    bw_en   = BUS_FAULT;
    bw_data = BUS_FAULT_ADDR; // see RULE_10 RULE_11 RULE_14
    if (!BUS_FAULT && wr_req && WB_ADR_I == ffar_pkg::OFS_BUS_ADDR) begin
      bw_en   = 1'b1;
      bw_data = merge(bus_word, WB_DAT_I, wmask);
    end
  end

  // Each capture word has a store of its own, so a variant with one shared location would
  // only change the read-back and not the capture path.
  ffar_word #(
    .WIDTH (ffar_pkg::DATA_W)
  ) u_prot_word (
    .clk     (MCLK),
    .rst     (SRST),
    .wr_en   (pw_en),
    .wr_data (pw_data),
    .rd_data (prot_word)
  );

  ffar_word #(
    .WIDTH (ffar_pkg::DATA_W)
  ) u_bus_word (
    .clk     (MCLK),
    .rst     (SRST),
    .wr_en   (bw_en),
    .wr_data (bw_data),
    .rd_data (bus_word)
  );

  //////////////////////////////////////////////////////////////////////////////////////////////////
  // Read mux and answer.
  // Read data is registered so that it stands for the whole ack cycle; it shows the state
  // of the cycle in which the request was taken.
  // Unmapped offsets answer with an error pulse, write nothing and return zero.

  always_comb begin
    rdata_next = rdata_reg;
    ack_next   = 1'b0;
    err_next   = 1'b0;
    if (req) begin
      ack_next   = hit;
      err_next   = !hit;
      rdata_next = ffar_pkg::RST_ZERO;
      if (!WB_WE_I) begin
        unique case (WB_ADR_I)
          ffar_pkg::OFS_CAUSE: begin
            rdata_next[ffar_pkg::BIT_DEBUG]  = debug_reg;
            rdata_next[ffar_pkg::BIT_FORCED] = forced_reg;
            rdata_next[ffar_pkg::BIT_VECTOR] = vector_reg; // see RULE_02
          end
          ffar_pkg::OFS_PROT_ADDR: begin
            // Invalid content reads as a fixed pattern rather than stale data.
            // Storage stays separate in shared mode; only the read-back follows that variant,
            // so switching the mode never loses a captured address.
            if (pvalid_reg && !(shared_reg && bvalid_reg)) begin // see RULE_05 RULE_08
              rdata_next = prot_word;
            end else begin
              rdata_next = ffar_pkg::UNKNOWN_WORD;
            end
          end
          ffar_pkg::OFS_BUS_ADDR: begin
            if (bvalid_reg && !(shared_reg && pvalid_reg)) begin // see RULE_09 RULE_12
              rdata_next = bus_word;
            end else begin
              rdata_next = ffar_pkg::UNKNOWN_WORD;
            end
          end
          ffar_pkg::OFS_AUX: begin
            rdata_next = ffar_pkg::RST_ZERO; // see RULE_13
          end
          ffar_pkg::OFS_STATUS: begin
            rdata_next[ffar_pkg::BIT_PROT_VALID] = pvalid_reg;
            rdata_next[ffar_pkg::BIT_BUS_VALID]  = bvalid_reg;
            rdata_next[ffar_pkg::BIT_PRECISE]    = precise_reg;
          end
          ffar_pkg::OFS_CONFIG: begin
            rdata_next[ffar_pkg::BIT_SHARED] = shared_reg;
          end
          default: begin
            rdata_next = ffar_pkg::RST_ZERO;
          end
        endcase
      end
    end
  end

  // The master sees ack or err one cycle after the taking edge; the req gate keeps a request
  // that is still standing in that cycle from being taken a second time.
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      ack_reg   <= 1'b0;
      err_reg   <= 1'b0;
      rdata_reg <= ffar_pkg::RST_ZERO;
    end else begin
      ack_reg   <= ack_next;
      err_reg   <= err_next;
      rdata_reg <= rdata_next;
    end
  end

  assign WB_ACK_O        = ack_reg;
  assign WB_ERR_O        = err_reg;
  assign WB_DAT_O        = rdata_reg;
  assign PROT_ADDR_VALID = pvalid_reg;
  assign BUS_ADDR_VALID  = bvalid_reg;
  assign PRECISE_ERROR   = precise_reg;

endmodule : ffar_regs

// [hdl/ffar_word.sv]
// Small word store used for the fault address capture registers.
`timescale 1ns/1ps
module ffar_word #(
  parameter int unsigned WIDTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wr_data,
  output logic      [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] word_reg;
  logic [WIDTH-1:0] word_next;

  initial begin
    if (WIDTH < 1) begin
      $error("ffar_word: WIDTH must be at least 1");
    end
  end

  always_comb begin
    word_next = wr_en ? wr_data : word_reg;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      word_reg <= '0;
    end else begin
      word_reg <= word_next;
    end
  end

  assign rd_data = word_reg;

endmodule : ffar_word

// [inc/ffar_pkg.sv]
// Package with register map, field positions and reset values of the fault report registers.
package ffar_pkg;

  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 32;

  // Word offsets of the registers on the Wishbone port (byte addresses).
  localparam logic [7:0] OFS_CAUSE     = 8'h00;
  localparam logic [7:0] OFS_PROT_ADDR = 8'h04;
  localparam logic [7:0] OFS_BUS_ADDR  = 8'h08;
  localparam logic [7:0] OFS_AUX       = 8'h0C;
  localparam logic [7:0] OFS_STATUS    = 8'h10;
  localparam logic [7:0] OFS_CONFIG    = 8'h14;

  // Escalated-fault cause register bit positions.
  localparam int unsigned BIT_DEBUG  = 31;
  localparam int unsigned BIT_FORCED = 30;
  localparam int unsigned BIT_VECTOR = 1;

  // Status register bit positions (validity flags and precise error flag).
  localparam int unsigned BIT_PROT_VALID = 0;
  localparam int unsigned BIT_BUS_VALID  = 1;
  localparam int unsigned BIT_PRECISE    = 2;

  // Config register bit position: selects the shared-storage variant.
  localparam int unsigned BIT_SHARED = 0;

  localparam logic [31:0] RST_ZERO     = 32'h0000_0000;
  // Value returned where a read is defined as unknown.
  localparam logic [31:0] UNKNOWN_WORD = 32'h0000_0000;

endpackage : ffar_pkg

// [tb/ffar_core_model.sv]
// Behavioural model of the core's fault detection side.
`timescale 1ns/1ps
module ffar_core_model (
  input  logic        clk,
  output logic        dbg,
  output logic        frc,
  output logic        vec,
  output logic        pf,
  output logic        bf,
  output logic [31:0] pa,
  output logic [31:0] ba
);
  initial begin
    {dbg, frc, vec, pf, bf} = 5'h0;
    pa = 32'h5A5A_5A5A;
    ba = 32'hA5A5_A5A5;
  end
  // Address lines mean nothing outside a pulse, so they toggle rather than hold.
  task automatic fire(input int k, input logic [31:0] a);
    @(posedge clk);
    dbg <= (k == 0);
    frc <= (k == 1);
    vec <= (k == 2);
    pf  <= (k == 3);
    bf  <= (k == 4);
    // A split unaligned access faults on its upper aligned part.
    pa  <= (a[1:0] != 2'h0) ? (a | 32'h3) + 32'h1 : a;
    ba  <= a;
    @(posedge clk);
    {dbg, frc, vec, pf, bf} <= 5'h0;
    pa  <= ~pa;
    ba  <= ~ba;
  endtask : fire
endmodule : ffar_core_model

// [tb/ffar_regs_properties.sv]
// Concurrent checks on the ports of the fault report register block.
`timescale 1ns/1ps
module ffar_regs_props (
  input logic        MCLK,
  input logic        SRST,
  input logic        WB_CYC_I,
  input logic        WB_STB_I,
  input logic        WB_WE_I,
  input logic [7:0]  WB_ADR_I,
  input logic [31:0] WB_DAT_O,
  input logic        WB_ACK_O,
  input logic        WB_ERR_O,
  input logic        PROT_FAULT,
  input logic        BUS_FAULT,
  input logic        PROT_ADDR_VALID,
  input logic        BUS_ADDR_VALID,
  input logic        PRECISE_ERROR
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SRST);
  logic rd_ack;
  // The master holds address and direction through the answer cycle.
  assign rd_ack = WB_ACK_O && !WB_WE_I;
  a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack longer than one cycle");
  a_answer_next: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O && !WB_ERR_O
    |=> WB_ACK_O || WB_ERR_O) else $error("no answer one cycle after request");
  a_err_map: assert property ((WB_ACK_O || WB_ERR_O) |-> WB_ERR_O ==
    !(WB_ADR_I inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14}))
    else $error("ack or err on wrong address");
  a_cause_resv: assert property (rd_ack && WB_ADR_I == 8'h00 |->
    WB_DAT_O[29:2] == 28'h0 && !WB_DAT_O[0]) else $error("reserved cause bit set");
  a_aux_zero: assert property (rd_ack && WB_ADR_I == 8'h0C |-> WB_DAT_O == 32'h0)
    else $error("auxiliary read not zero");
  a_bus_unknown: assert property (rd_ack && WB_ADR_I == 8'h08 && !BUS_ADDR_VALID
    |-> WB_DAT_O == ffar_pkg::UNKNOWN_WORD) else $error("invalid bus address shown");
  a_prot_cap: assert property (PROT_FAULT |=> PROT_ADDR_VALID)
    else $error("protection valid not set");
  a_bus_cap: assert property (BUS_FAULT |=> BUS_ADDR_VALID && PRECISE_ERROR)
    else $error("bus valid or precise flag not set");
  a_prec_cause: assert property ($rose(PRECISE_ERROR) |-> $past(BUS_FAULT))
    else $error("precise flag without bus fault");
  a_pval_cause: assert property ($rose(PROT_ADDR_VALID) |-> $past(PROT_FAULT))
    else $error("protection valid without fault");
  c_err: cover property (WB_ERR_O);
  c_prot_rd: cover property (rd_ack && WB_ADR_I == 8'h04 && PROT_ADDR_VALID);
  c_bus: cover property (BUS_FAULT);
endmodule : ffar_regs_props
////////////////////////////////////////
bind ffar_regs ffar_regs_props chk_u (.*);

// [tb/testbench.sv]
// Self-checking bench for the fault report register block.
`timescale 1ns/1ps
module testbench;
  logic        MCLK = 1'b0;
  logic        SRST = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'hF, wsel = 4'hF;
  logic [31:0] dat = 32'h0, q, rnd = 32'hB4C92338;
  logic        ack, err, dbg, frc, vec, pf, bf, pv, bv, pe;
  logic [31:0] pa, ba;
  int          errors = 0, check_count = 0;
  logic [31:0] m_cause = 0, m_pa = 0, m_ba = 0, m_st = 0, m_cfg = 0;
  always #10 MCLK = ~MCLK;
  ffar_core_model model_u (.clk(MCLK), .dbg(dbg), .frc(frc), .vec(vec), .pf(pf), .bf(bf),
    .pa(pa), .ba(ba));
  ffar_regs dut_u (.MCLK(MCLK), .SRST(SRST), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(q), .WB_ACK_O(ack),
    .WB_ERR_O(err), .DEBUG_FAULT(dbg), .FORCED_FAULT(frc), .VECTOR_READ_FAULT(vec),
    .PROT_FAULT(pf), .PROT_FAULT_ADDR(pa), .BUS_FAULT(bf), .BUS_FAULT_ADDR(ba),
    .PROT_ADDR_VALID(pv), .BUS_ADDR_VALID(bv), .PRECISE_ERROR(pe));
  ////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // An unknown read is modelled as zero, matching the hand-over choice.
  function automatic logic [32:0] exp_rd(input logic [7:0] a);
    case (a)
      8'h00: return {1'b0, m_cause};
      8'h04: return {1'b0, (m_st[0] && !(m_cfg[0] && m_st[1])) ? m_pa : 32'h0};
      8'h08: return {1'b0, (m_st[1] && !(m_cfg[0] && m_st[0])) ? m_ba : 32'h0};
      8'h10: return {1'b0, m_st};
      8'h14: return {1'b0, m_cfg};
      8'h0C: return 33'h0;
      default: return 33'h1_0000_0000;
    endcase
  endfunction : exp_rd
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic [31:0] msk;
    logic [32:0] e;
    @(posedge MCLK);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= wsel;
    dat <= d;
    do begin
      @(posedge MCLK);
    end while (!(ack || err));
    e = exp_rd(a);
    chk({err, w ? 32'h0 : q}, w ? {e[32], 32'h0} : e);
    cyc <= 1'b0;
    stb <= 1'b0;
    msk = {{8{wsel[3]}}, {8{wsel[2]}}, {8{wsel[1]}}, {8{wsel[0]}}};
    if (w) case (a)
      8'h00: m_cause &= ~(d & msk);
      8'h04: m_pa = (m_pa & ~msk) | (d & msk);
      8'h08: m_ba = (m_ba & ~msk) | (d & msk);
      8'h10: m_st &= ~(d & {29'h0, {3{wsel[0]}}});
      8'h14: if (wsel[0]) m_cfg = d & 32'h1;
      default: ;
    endcase
    chk({30'h0, pe, bv, pv}, {1'b0, m_st});
  endtask : acc
  task automatic fault(input int k, input logic [31:0] a);
    model_u.fire(k, a);
    case (k)
      0: m_cause |= 32'h8000_0000;
      1: m_cause |= 32'h4000_0000;
      2: m_cause |= 32'h0000_0002;
      3: m_st |= 32'h1;
      default: m_st |= 32'h6;
    endcase
    if (k == 3) m_pa = (a[1:0] != 2'h0) ? (a | 32'h3) + 32'h1 : a;
    if (k == 4) m_ba = a;
  endtask : fault
  task automatic summarize;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  ////////////////////////////////////////
  initial begin
    #200000;
    errors++;
    summarize();
  end
  initial begin
    repeat (3) @(posedge MCLK);
    SRST <= 1'b0;
    for (int a = 0; a <= 24; a += 4) acc(1'b0, 8'(a), 32'h0);
    acc(1'b1, 8'h0C, 32'hFFFF_FFFF);
    acc(1'b0, 8'h0C, 32'h0);
    acc(1'b0, 8'h02, 32'h0);
    acc(1'b1, 8'h06, 32'hFFFF_FFFF);
    for (int k = 0; k < 3; k++) fault(k, 32'h0);
    acc(1'b0, 8'h00, 32'h0);
    acc(1'b1, 8'h00, 32'hBFFF_FFFF);
    acc(1'b0, 8'h00, 32'h0);
    acc(1'b1, 8'h00, 32'h0);
    acc(1'b0, 8'h00, 32'h0);
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      fault(3, {rnd[31:2], 2'(i)});
      acc(1'b0, 8'h08, 32'h0);
      acc(1'b0, 8'h04, 32'h0);
      rnd = lfsr(rnd);
      fault(4, {rnd[31:2], 2'(i + 1)});
      acc(1'b0, 8'h08, 32'h0);
      acc(1'b0, 8'h10, 32'h0);
    end
    acc(1'b1, 8'h14, 32'h1);
    acc(1'b0, 8'h04, 32'h0);
    acc(1'b0, 8'h08, 32'h0);
    acc(1'b1, 8'h10, 32'h2);
    acc(1'b0, 8'h04, 32'h0);
    acc(1'b1, 8'h04, rnd);
    acc(1'b0, 8'h04, 32'h0);
    acc(1'b1, 8'h10, 32'h7);
    acc(1'b0, 8'h04, 32'h0);
    acc(1'b0, 8'h10, 32'h0);
    rnd = lfsr(rnd);
    fault(4, rnd);
    wsel = 4'h3;
    acc(1'b1, 8'h08, ~rnd);
    wsel = 4'hE;
    acc(1'b1, 8'h10, 32'h7);
    wsel = 4'hF;
    acc(1'b0, 8'h08, 32'h0);
    acc(1'b0, 8'h10, 32'h0);
    @(posedge MCLK);
    SRST <= 1'b1;
    repeat (3) @(posedge MCLK);
    SRST <= 1'b0;
    {m_cause, m_pa, m_ba, m_st, m_cfg} = 160'h0;
    for (int a = 0; a <= 20; a += 4) acc(1'b0, 8'(a), 32'h0);
    summarize();
  end
endmodule : testbench
